/* hdl/prt_divider.sv */
/*
 * restoring divider for the temperature ratio, one quotient bit per clock.
 * assumes go is a single-cycle pulse given while busy is low.
 */
`timescale 1ns/10ps

module prt_divider #(
	parameter int DW = 27,
	parameter int SW = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic go,
	input wire logic [DW-1:0] dividend,
	input wire logic [SW-1:0] divisor,
	output logic busy,
	output logic done,
	output logic [DW-1:0] quotient
);

	logic [DW-1:0] quo_reg;
	logic [SW:0] rem_reg;
	logic [5:0] step_reg;
	logic busy_reg;
	logic done_reg;
	logic [SW:0] rem_shift;
	logic [SW:0] rem_diff;
	logic fits;

	// ************************************************************
	// one trial subtraction per cycle
	// ************************************************************
	assign rem_shift = {rem_reg[SW-1:0], quo_reg[DW-1]};
	assign fits = rem_shift >= {1'b0, divisor};
	assign rem_diff = rem_shift - {1'b0, divisor};

	// remainder stays below divisor, so SW+1 bits never overflow
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			quo_reg <= '0;
			rem_reg <= '0;
			step_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (go) begin
			quo_reg <= dividend;
			rem_reg <= '0;
			step_reg <= 6'(DW);
			busy_reg <= 1'b1;
			done_reg <= 1'b0;
		end else if (busy_reg) begin
			quo_reg <= {quo_reg[DW-2:0], fits};
			rem_reg <= fits ? rem_diff : rem_shift;
			step_reg <= step_reg - 6'h01;
			busy_reg <= step_reg != 6'h01;
			done_reg <= step_reg == 6'h01;
		end else begin
			done_reg <= 1'b0;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
	assign quotient = quo_reg;

endmodule

/* hdl/prt_pkg.sv */
/*
 * shared constants for the pulse-ratio temperature readout (host side).
 * assumes one 100 MHz clock and a sensor output pin that idles in either
 * level and toggles at a few tens of hertz.
 */

package prt_pkg;

	// ************************************************************
	// clocking and counting
	// ************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_HZ = 1_000_000;
	localparam int PRESCALE_DIV = CLK_HZ / TICK_HZ;
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_PRELOAD = 16'hffff;
	localparam int MAX_PHASE_MS = 32;

	// ************************************************************
	// temperature arithmetic, result in 14.2 fixed point
	// ************************************************************
	localparam int DIV_W = 27;
	localparam logic [31:0] TEMP_SCALE_Q2 = 32'h0000_0640;
	localparam logic [15:0] TEMP_OFFSET_Q2 = 16'h03ac;

	// ************************************************************
	// capture sequencer states
	// ************************************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_WAIT_IDLE = 5'b00010,
		ST_WAIT_START = 5'b00100,
		ST_FIRST = 5'b01000,
		ST_SECOND = 5'b10000
	} prt_state_t;

endpackage

/* hdl/prt_readout.sv */
/*
 * host-side capture of a duty-cycle temperature sensor on one input pin.
 * assumes sense_in is the raw sensor output, asynchronous to clk, and
 * that start is a pulse from local control logic.
 */
`timescale 1ns/10ps

module prt_readout #(
	parameter int PRESCALE = prt_pkg::PRESCALE_DIV,
	parameter int CW = prt_pkg::CNT_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sense_in,
	input wire logic start,
	input wire logic continuous,
	input wire logic single_mode,
	output logic busy,
	output logic meas_done,
	output logic phase_level,
	output logic timeout_err,
	output logic [CW-1:0] high_phase_time,
	output logic [CW-1:0] low_phase_time,
	output logic temp_valid,
	output logic temp_range_err,
	output logic [15:0] temp_c_q2
);

	// ************************************************************
	// declarations
	// ************************************************************
	prt_pkg::prt_state_t state_reg, state_next;
	logic sense_meta_reg, sense_sync_reg, sense_prev_reg;
	logic [7:0] presc_reg;
	logic tick;
	logic [CW-1:0] cnt_reg [2];
	logic [CW-1:0] high_reg, low_reg;
	logic single_reg, cont_reg, err_reg, done_reg;
	logic edge_seen;
	logic first_lvl;
	logic counting;
	logic sel;
	logic [CW-1:0] elapsed;
	logic overflow;
	logic reload;
	logic latch_now;
	logic finish;
	logic [31:0] scaled;
	logic div_done;
	logic [prt_pkg::DIV_W-1:0] quo;
	logic temp_valid_reg, range_err_reg;
	logic [15:0] temp_reg;

	// ************************************************************
	// input synchroniser and edge strobe
	// ************************************************************
	// meta_reg is the first stage, read by nothing but sync_reg
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sense_meta_reg <= 1'b0;
			sense_sync_reg <= 1'b0;
			sense_prev_reg <= 1'b0;
		end else begin
			sense_meta_reg <= sense_in;
			sense_sync_reg <= sense_meta_reg;
			sense_prev_reg <= sense_sync_reg;
		end
	end

	// one strobe per transition in either direction
	assign edge_seen = sense_sync_reg ^ sense_prev_reg;

	// ************************************************************
	// prescaler, counts PRESCALE-1 down to zero
	// ************************************************************
	// exact rate is irrelevant to the ratio, only its stability
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			presc_reg <= 8'h00;
		end else if (presc_reg == 8'h00) begin
			presc_reg <= 8'(PRESCALE - 1);
		end else begin
			presc_reg <= presc_reg - 8'h01;
		end
	end

	assign tick = presc_reg == 8'h00;

	// ************************************************************
	// phase steering and capture decode
	// ************************************************************
	// dual mode starts on a rise, single-counter mode on a fall
	assign first_lvl = ~single_reg;
	assign counting = (state_reg == prt_pkg::ST_FIRST) ||
		(state_reg == prt_pkg::ST_SECOND);
	// phase being timed is the level before any strobe
	assign sel = single_reg ? 1'b0 : ~sense_prev_reg;
	assign elapsed = prt_pkg::CNT_PRELOAD - cnt_reg[sel];
	assign overflow = counting && elapsed[CW-1];
	assign latch_now = counting && edge_seen && !overflow;
	assign finish = latch_now && (state_reg == prt_pkg::ST_SECOND);
	assign reload = latch_now || (state_reg == prt_pkg::ST_WAIT_START)
		|| (state_reg == prt_pkg::ST_IDLE);

	// ************************************************************
	// the two down counters
	// ************************************************************
	// single-counter mode only ever steers counter zero
	for (genvar i = 0; i < 2; i++) begin : g_cnt
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				cnt_reg[i] <= prt_pkg::CNT_PRELOAD;
			end else if (reload) begin
				cnt_reg[i] <= prt_pkg::CNT_PRELOAD;
			end else if (counting && tick && sel == 1'(i)) begin
				cnt_reg[i] <= cnt_reg[i] - 16'h0001;
			end
		end
	end

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			prt_pkg::ST_IDLE: begin
				if (start) begin
					state_next = prt_pkg::ST_WAIT_IDLE;
				end
			end
			prt_pkg::ST_WAIT_IDLE: begin
				if (sense_sync_reg != first_lvl) begin
					state_next = prt_pkg::ST_WAIT_START;
				end
			end
			prt_pkg::ST_WAIT_START: begin
				if (edge_seen && sense_sync_reg == first_lvl) begin
					state_next = prt_pkg::ST_FIRST;
				end
			end
			prt_pkg::ST_FIRST: begin
				if (overflow) begin
					state_next = prt_pkg::ST_IDLE;
				end else if (edge_seen) begin
					state_next = prt_pkg::ST_SECOND;
				end
			end
			prt_pkg::ST_SECOND: begin
				if (overflow) begin
					state_next = prt_pkg::ST_IDLE;
				end else if (edge_seen) begin
					state_next = cont_reg ? prt_pkg::ST_FIRST :
						prt_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = prt_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= prt_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// mode capture, holding registers and status
	// ************************************************************
	// modes are frozen at start so a change mid-measurement is harmless
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			single_reg <= 1'b0;
			cont_reg <= 1'b0;
			err_reg <= 1'b0;
			done_reg <= 1'b0;
			high_reg <= '0;
			low_reg <= '0;
		end else begin
			done_reg <= finish;
			if (overflow) begin
				err_reg <= 1'b1;
			end else if (state_reg == prt_pkg::ST_IDLE && start) begin
				err_reg <= 1'b0;
			end
			if (state_reg == prt_pkg::ST_IDLE && start) begin
				single_reg <= single_mode;
				cont_reg <= continuous;
			end
			// present level high means the low phase just ended
			if (latch_now && sense_sync_reg) begin
				low_reg <= elapsed;
			end
			if (latch_now && !sense_sync_reg) begin
				high_reg <= elapsed;
			end
		end
	end

	// ************************************************************
	// temperature: 235 - 400 * high / low, scaled by four
	// ************************************************************
	// both counts are only consistent right after a finished pair
	assign scaled = {16'h0000, high_reg} * prt_pkg::TEMP_SCALE_Q2;

	prt_divider #(
		.DW(prt_pkg::DIV_W),
		.SW(CW)
	) u_div (
		.clk(clk),
		.sys_rst(sys_rst),
		.go(done_reg && low_reg != '0),
		.dividend(scaled[prt_pkg::DIV_W-1:0]),
		.divisor(low_reg),
		.busy(),
		.done(div_done),
		.quotient(quo)
	);

	// a zero low count or a huge ratio cannot be a real reading
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			temp_valid_reg <= 1'b0;
			range_err_reg <= 1'b0;
			temp_reg <= 16'h0000;
		end else if (done_reg && low_reg == '0) begin
			temp_valid_reg <= 1'b0;
			range_err_reg <= 1'b1;
		end else if (div_done) begin
			temp_valid_reg <= 1'b1;
			range_err_reg <= |quo[prt_pkg::DIV_W-1:15];
			temp_reg <= prt_pkg::TEMP_OFFSET_Q2 - quo[15:0];
		end else if (state_reg == prt_pkg::ST_IDLE && start) begin
			temp_valid_reg <= 1'b0;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign busy = state_reg != prt_pkg::ST_IDLE;
	assign meas_done = done_reg;
	assign phase_level = sense_sync_reg;
	assign timeout_err = err_reg;
	assign high_phase_time = high_reg;
	assign low_phase_time = low_reg;
	assign temp_valid = temp_valid_reg;
	assign temp_range_err = range_err_reg;
	assign temp_c_q2 = temp_reg;

endmodule

/* verif/prt_readout_chk.sv */
/*
 * port assertions for the pulse-ratio readout.
 * assumes it is bound onto prt_readout, one clock, async reset.
 */
`timescale 1ns/10ps

module prt_readout_chk #(
	parameter int CW = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sense_in,
	input wire logic start,
	input wire logic busy,
	input wire logic meas_done,
	input wire logic phase_level,
	input wire logic timeout_err,
	input wire logic [CW-1:0] high_phase_time,
	input wire logic [CW-1:0] low_phase_time,
	input wire logic temp_valid
);
	// ****
	// helpers
	// ****
	logic [1:0] up_reg;
	wire logic acc = start && !busy;

	// edges since reset, so the $past in p_sync never looks back into reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			up_reg <= 2'h0;
		end else if (up_reg != 2'h3) begin
			up_reg <= up_reg + 2'h1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ****
	// properties
	// ****
	property p_pulse; meas_done |=> !meas_done; endproperty
	property p_hold;
		($changed(high_phase_time) || $changed(low_phase_time)) |-> $past(busy);
	endproperty
	property p_sticky; timeout_err && !acc |=> timeout_err; endproperty
	property p_clr; acc |=> !timeout_err && !temp_valid; endproperty
	property p_sync;
		up_reg == 2'h3 |-> phase_level == $past(sense_in, 2);
	endproperty
	property p_tlat; $rose(temp_valid) |-> $past(meas_done, 29); endproperty
	property p_take; acc |=> busy; endproperty
	property p_abort; $rose(timeout_err) |-> ##[0:2] !busy; endproperty

	a_pulse: assert property (p_pulse)
		else $error("done pulse too long");
	a_hold: assert property (p_hold)
		else $error("count changed while idle");
	a_sticky: assert property (p_sticky)
		else $error("error flag dropped");
	a_clr: assert property (p_clr)
		else $error("flags not cleared by start");
	a_sync: assert property (p_sync)
		else $error("level not two flops behind");
	a_tlat: assert property (p_tlat)
		else $error("result latency wrong");
	a_take: assert property (p_take)
		else $error("start not taken");
	a_abort: assert property (p_abort)
		else $error("no abort on overflow");

	c_done: cover property (meas_done);
	c_to: cover property ($rose(timeout_err));
	c_tv: cover property ($rose(temp_valid));
endmodule

bind prt_readout prt_readout_chk #(.CW(CW)) prt_readout_chk_inst (
	.clk(clk), .sys_rst(sys_rst), .sense_in(sense_in), .start(start),
	.busy(busy), .meas_done(meas_done), .phase_level(phase_level),
	.timeout_err(timeout_err), .high_phase_time(high_phase_time),
	.low_phase_time(low_phase_time), .temp_valid(temp_valid)
);

/* verif/prt_readout_test.sv */
/*
 * self-checking bench for the pulse-ratio readout.
 * assumes a tick every 2 clocks, so counts are half the phase cycles.
 */
`timescale 1ns/10ps

module prt_readout_test;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic start = 1'b0;
	logic continuous = 1'b0;
	logic single_mode = 1'b0;
	logic sense, busy, meas_done, phase_level, timeout_err;
	logic temp_valid, temp_range_err;
	logic [15:0] high_phase_time, low_phase_time, temp_c_q2;
	int hi_cyc = 200;
	int lo_cyc = 300;
	int errors = 0;
	int n_checks = 0;
	int seed = 44;
	int i, h;

	// ****
	// clock, sensor, design
	// ****
	always #5 clk = ~clk;

	prt_sensor_model prt_sensor_model_inst (.clk(clk), .hi_cyc(hi_cyc),
		.lo_cyc(lo_cyc), .sense(sense));

	prt_readout #(.PRESCALE(2)) prt_readout_inst (.clk(clk),
		.sys_rst(sys_rst), .sense_in(sense), .start(start),
		.continuous(continuous), .single_mode(single_mode), .busy(busy),
		.meas_done(meas_done), .phase_level(phase_level),
		.timeout_err(timeout_err), .high_phase_time(high_phase_time),
		.low_phase_time(low_phase_time), .temp_valid(temp_valid),
		.temp_range_err(temp_range_err), .temp_c_q2(temp_c_q2));

	// ****
	// helpers
	// ****
	// counts carry one tick of doubt from the free-running prescaler
	function automatic logic near(input logic [15:0] got, input int want);
		return (got + 16'h0001 >= want) && (got <= want + 1);
	endfunction

	function automatic int t_exp(input int hh, input int ll);
		return 940 - (1600 * hh) / ll;
	endfunction

	task automatic chk(input logic ok, input logic [31:0] got,
		input logic [31:0] exp);
		n_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// bounded wait: 0 done, 1 result, 2 overflow flag
	task automatic wait_ev(input int sel, input int lim);
		logic hit;
		for (int k = 0; k < lim; k++) begin
			@(posedge clk);
			#1;
			hit = sel == 0 ? meas_done : sel == 1 ?
				(temp_valid | temp_range_err) : timeout_err;
			if (hit === 1'b1) return;
		end
		chk(1'b0, sel, lim);
		give_verdict;
	endtask

	task automatic kick(input logic s, input logic c);
		@(posedge clk);
		start <= 1'b1;
		single_mode <= s;
		continuous <= c;
		@(posedge clk);
		start <= 1'b0;
	endtask

	task automatic measure(input int hh, input int ll, input logic s);
		hi_cyc = 2 * hh;
		lo_cyc = 2 * ll;
		kick(s, 1'b0);
		wait_ev(0, 9000);
		chk(near(high_phase_time, hh), high_phase_time, hh);
		chk(near(low_phase_time, ll), low_phase_time, ll);
		wait_ev(1, 40);
		if (1600 * (hh - 1) >= 32768 * (ll + 1)) begin
			chk(temp_range_err === 1'b1, temp_range_err, 1);
		end else begin
			chk(temp_valid === 1'b1 && $signed(temp_c_q2) >= t_exp(hh + 1,
				ll - 1) && $signed(temp_c_q2) <= t_exp(hh - 1, ll + 1),
				temp_c_q2, t_exp(hh, ll));
		end
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		measure(100, 150, 1'b0);
		for (i = 0; i < 6; i++) begin
			h = 40 + ($unsigned($random(seed)) % 100);
			measure(h, h + 20 + ($unsigned($random(seed)) % 120), 1'b0);
		end
		measure(30, 90, 1'b1);
		measure(150, 60, 1'b1);
		measure(200, 1, 1'b0);
		// back-to-back pairs, a refused start, then reset mid-run
		hi_cyc = 160;
		lo_cyc = 240;
		kick(1'b0, 1'b1);
		for (i = 0; i < 2; i++) begin
			wait_ev(0, 2000);
			chk(near(low_phase_time, 120), low_phase_time, 120);
		end
		kick(1'b0, 1'b0);
		#1;
		chk(busy === 1'b1, busy, 1);
		// the refused start must leave the running pairs untouched
		wait_ev(0, 2000);
		chk(near(high_phase_time, 80), high_phase_time, 80);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(busy === 1'b0 && high_phase_time === 16'h0000, busy, 0);
		@(posedge clk);
		sys_rst <= 1'b0;
		// stuck-high output must trip the overflow flag
		hi_cyc = 66000;
		kick(1'b0, 1'b0);
		wait_ev(2, 70000);
		chk(meas_done === 1'b0, meas_done, 0);
		repeat (3) @(posedge clk);
		#1;
		chk(busy === 1'b0, busy, 0);
		measure(100, 150, 1'b0);
		chk(timeout_err === 1'b0, timeout_err, 0);
		give_verdict;
	end
endmodule

/* verif/prt_sensor_model.sv */
/*
 * behavioural duty-cycle sensor for the readout bench.
 * assumes the bench sets the phase lengths in clock cycles, at least one.
 */
`timescale 1ns/10ps

module prt_sensor_model (
	input wire logic clk,
	input wire logic [31:0] hi_cyc,
	input wire logic [31:0] lo_cyc,
	output logic sense
);
	// ****
	// free-running output
	// ****
	initial sense = 1'b0;

	// edges follow the rising clock by nba, so sampling never races;
	// the wait stops a zero-time spin before the lengths arrive
	always begin
		wait (lo_cyc > 0 && hi_cyc > 0);
		repeat (lo_cyc) @(posedge clk);
		sense <= 1'b1;
		repeat (hi_cyc) @(posedge clk);
		sense <= 1'b0;
	end
endmodule
